// ---- hw/adc_readout_pkg.sv ----
// Shared constants and types for the converter serial readout port
`default_nettype none

package adc_readout_pkg;

    // =========================================================
    // Conversion modes as seen on the mode input
    localparam logic [1:0] MODE_CONT_CONV = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_CONT_READ = 2'h2;

    // =========================================================
    // Clock source select: both bits set picks external clock over two
    localparam logic [1:0] CLK_SRC_INTERNAL = 2'h0;
    localparam logic [1:0] CLK_SRC_EXT_DIV2 = 2'h3;
    localparam int EXT_CLK_KHZ = 128;
    localparam int MOD_CLK_KHZ = 64;
    localparam int EXT_CLK_DIVIDE = EXT_CLK_KHZ / MOD_CLK_KHZ;

    // =========================================================
    // Reset values
    localparam logic [3:0] WORD_RATE_RST = 4'h0;
    localparam logic RDY_N_RST = 1'b1;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic OE_N_RELEASED = 1'b1;
    localparam logic [5:0] BIT_CNT_RST = 6'h00;

    // =========================================================
    // Combined data-out / ready pin: driven value and its enable
    typedef struct packed {
        logic data;
        logic oe_n;
    } line_out_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READY,
        ST_SHIFT,
        ST_DONE
    } read_state_t;

endpackage

`default_nettype wire

// ---- hw/adc_serial_readout_port.sv ----
// Serial readout port of a sigma-delta converter, device side
// Notes on behaviour
// - Read data changes on the falling serial clock edge, the active edge.
// - After a completed read the ready flag goes high until next update.
// - Single and continuous conversion modes allow re-reading while ready high.
// - Continuous read mode gives each result for one read only.
// - A four-bit word rate select field sets the output word rate.
// - Select falling takes the data/ready line out of high impedance.
// - Select rising releases the data/ready line to high impedance.
// - After the final inactive clock edge the line returns high.
// - Both clock select bits set divide a 128 kHz external clock by two.
`timescale 1ns/1ps
`default_nettype none

module adc_serial_readout_port
    import adc_readout_pkg::*;
#(
    parameter int DATA_W = 24
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [1:0] conv_mode,
    input wire logic [3:0] word_rate_select,
    input wire logic clock_source_sel_hi,
    input wire logic clock_source_sel_lo,
    input wire logic int_osc_clk,
    input wire logic ext_clk,
    input wire logic result_valid,
    input wire logic [DATA_W-1:0] result_data,
    output line_out_t line_out,
    output logic rdy_n,
    output logic mod_clk,
    output logic [3:0] word_rate
);

    // =========================================================
    // Edge detection on the serial clock and external clock
    logic sclk_q_ff;
    logic ext_q_ff;
    logic sclk_fall;
    logic sclk_rise;
    logic ext_rise;
    logic [1:0] clk_src;

    assign sclk_fall = sclk_q_ff && !sclk;
    assign sclk_rise = !sclk_q_ff && sclk;
    assign ext_rise = !ext_q_ff && ext_clk;
    assign clk_src = {clock_source_sel_hi, clock_source_sel_lo};

    // =========================================================
    // Readout state
    read_state_t state_ff, nxt_state;
    logic [DATA_W-1:0] word_ff, nxt_word;
    logic [DATA_W-1:0] shift_ff, nxt_shift;
    logic [5:0] cnt_ff, nxt_cnt;
    logic consumed_ff, nxt_consumed;
    logic rdy_n_ff, nxt_rdy_n;
    line_out_t line_ff, nxt_line;
    logic mod_clk_ff, nxt_mod_clk;
    logic [3:0] rate_ff, nxt_rate;
    logic load;
    logic end_of_read;
    logic [DATA_W-1:0] load_word;

    // Two's complement from the core becomes offset binary
    function automatic logic [DATA_W-1:0] to_offset_bin(
        input logic [DATA_W-1:0] v
    );
        to_offset_bin = {~v[DATA_W-1], v[DATA_W-2:0]};
    endfunction

    assign load = sclk_fall && !cs_n
        && (state_ff == ST_READY || state_ff == ST_DONE);
    assign end_of_read = sclk_rise && !cs_n && state_ff == ST_SHIFT
        && cnt_ff == 6'(DATA_W);
    // A consumed word in continuous read mode reads back as all ones
    assign load_word = (conv_mode == MODE_CONT_READ && consumed_ff)
        ? '1 : word_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_word = word_ff;
        nxt_shift = shift_ff;
        nxt_cnt = cnt_ff;
        nxt_consumed = consumed_ff;
        nxt_rdy_n = rdy_n_ff;
        nxt_line = line_ff;
        if (cs_n) begin
            nxt_state = ST_IDLE;
            nxt_line.oe_n = OE_N_RELEASED;
            nxt_line.data = LINE_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    nxt_state = ST_READY;
                    nxt_line.oe_n = 1'b0;
                    nxt_line.data = rdy_n_ff;
                end
                ST_READY, ST_DONE: begin
                    if (load) begin
                        nxt_shift = {load_word[DATA_W-2:0], 1'b1};
                        nxt_line.data = load_word[DATA_W-1];
                        nxt_cnt = 6'h01;
                        nxt_state = ST_SHIFT;
                    end else if (state_ff == ST_READY) begin
                        nxt_line.data = rdy_n_ff;
                    end
                end
                ST_SHIFT: begin
                    if (sclk_fall && cnt_ff < 6'(DATA_W)) begin
                        nxt_line.data = shift_ff[DATA_W-1];
                        nxt_shift = {shift_ff[DATA_W-2:0], 1'b1};
                        nxt_cnt = cnt_ff + 6'h01;
                    end else if (end_of_read) begin
                        nxt_line.data = LINE_IDLE;
                        nxt_rdy_n = 1'b1;
                        nxt_state = ST_DONE;
                        if (conv_mode == MODE_CONT_READ) begin
                            nxt_consumed = 1'b1;
                        end
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                end
            endcase
        end
        // New result wins over the read completion in the same cycle
        if (result_valid) begin
            nxt_word = to_offset_bin(result_data);
            nxt_rdy_n = 1'b0;
            nxt_consumed = 1'b0;
        end
    end

    // =========================================================
    // Modulator clock and word rate
    always_comb begin
        nxt_rate = word_rate_select;
        case (clk_src)
            CLK_SRC_INTERNAL: nxt_mod_clk = int_osc_clk;
            CLK_SRC_EXT_DIV2: begin
                // Toggle per external rising edge divides it by two
                nxt_mod_clk = ext_rise ? !mod_clk_ff : mod_clk_ff;
            end
            default: nxt_mod_clk = ext_clk;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            sclk_q_ff <= 1'b1;
            ext_q_ff <= 1'b0;
            state_ff <= ST_IDLE;
            word_ff <= '0;
            shift_ff <= '1;
            cnt_ff <= BIT_CNT_RST;
            consumed_ff <= 1'b0;
            rdy_n_ff <= RDY_N_RST;
            line_ff <= '{data: LINE_IDLE, oe_n: OE_N_RELEASED};
            mod_clk_ff <= 1'b0;
            rate_ff <= WORD_RATE_RST;
        end else begin
            sclk_q_ff <= sclk;
            ext_q_ff <= ext_clk;
            state_ff <= nxt_state;
            word_ff <= nxt_word;
            shift_ff <= nxt_shift;
            cnt_ff <= nxt_cnt;
            consumed_ff <= nxt_consumed;
            rdy_n_ff <= nxt_rdy_n;
            line_ff <= nxt_line;
            mod_clk_ff <= nxt_mod_clk;
            rate_ff <= nxt_rate;
        end
    end

    assign line_out = line_ff;
    assign rdy_n = rdy_n_ff;
    assign mod_clk = mod_clk_ff;
    assign word_rate = rate_ff;

    // =========================================================
    // Assertions
    property p_shift_on_fall;
        @(posedge ref_clk) disable iff (!rstn)
        (state_ff == ST_SHIFT && !cs_n && sclk_fall
            && cnt_ff < 6'(DATA_W))
        |=> line_ff.data == $past(shift_ff[DATA_W-1]);
    endproperty
    a_shift_on_fall: assert property (p_shift_on_fall)
        else $error("data did not follow falling clock edge");

    property p_hold_between_falls;
        @(posedge ref_clk) disable iff (!rstn)
        (state_ff == ST_SHIFT && !cs_n && !sclk_fall)
        |=> $stable(line_ff.data) || line_ff.data;
    endproperty
    a_hold_between_falls: assert property (p_hold_between_falls)
        else $error("data changed off the falling edge");

    property p_rdy_high_after_read;
        @(posedge ref_clk) disable iff (!rstn)
        (end_of_read && !result_valid) |=> rdy_n_ff
            ##1 (rdy_n_ff || $past(result_valid));
    endproperty
    a_rdy_high_after_read: assert property (p_rdy_high_after_read)
        else $error("ready not high after read");

    property p_reread;
        @(posedge ref_clk) disable iff (!rstn)
        (load && conv_mode != MODE_CONT_READ)
        |=> line_ff.data == $past(word_ff[DATA_W-1]);
    endproperty
    a_reread: assert property (p_reread)
        else $error("held word not shifted on re-read");

    property p_single_read;
        @(posedge ref_clk) disable iff (!rstn)
        (load && conv_mode == MODE_CONT_READ && consumed_ff)
        |=> line_ff.data;
    endproperty
    a_single_read: assert property (p_single_read)
        else $error("consumed word read twice");

    property p_rate;
        @(posedge ref_clk) disable iff (!rstn)
        1'b1 |=> rate_ff == $past(word_rate_select);
    endproperty
    a_rate: assert property (p_rate)
        else $error("word rate not taken");

    property p_drive_on_select;
        @(posedge ref_clk) disable iff (!rstn)
        (!cs_n && state_ff == ST_IDLE) |=> !line_ff.oe_n [*1];
    endproperty
    a_drive_on_select: assert property (p_drive_on_select)
        else $error("line not driven after select");

    property p_release;
        @(posedge ref_clk) disable iff (!rstn)
        cs_n |=> line_ff.oe_n && state_ff == ST_IDLE;
    endproperty
    a_release: assert property (p_release)
        else $error("line not released");

    property p_line_high_at_end;
        @(posedge ref_clk) disable iff (!rstn)
        end_of_read |=> line_ff.data && state_ff == ST_DONE;
    endproperty
    a_line_high_at_end: assert property (p_line_high_at_end)
        else $error("line not high after last edge");

    property p_div2;
        @(posedge ref_clk) disable iff (!rstn)
        (clk_src == CLK_SRC_EXT_DIV2 && ext_rise)
        |=> mod_clk_ff != $past(mod_clk_ff);
    endproperty
    a_div2: assert property (p_div2)
        else $error("external clock not divided");

    property p_offset_bin;
        @(posedge ref_clk) disable iff (!rstn)
        result_valid |=> word_ff[DATA_W-1] != $past(result_data[DATA_W-1])
            && !rdy_n_ff;
    endproperty
    a_offset_bin: assert property (p_offset_bin)
        else $error("result not offset binary");

    c_full_read: cover property (@(posedge ref_clk) disable iff (!rstn)
        end_of_read);
    c_reread: cover property (@(posedge ref_clk) disable iff (!rstn)
        load && state_ff == ST_DONE);
    c_consumed: cover property (@(posedge ref_clk) disable iff (!rstn)
        load && consumed_ff);

endmodule

`default_nettype wire

// ---- tb/adc_serial_readout_port_tb.sv ----
// Self-checking bench for the converter serial readout port
`timescale 1ns/1ps
`default_nettype none

module adc_serial_readout_port_tb;
    import adc_readout_pkg::*;
    // ============================================================
    // Stimulus and observed signals
    logic ref_clk = 1'b0, rstn, sclk, cs_n, sel_hi, sel_lo;
    logic int_osc_clk = 1'b0, ext_clk, result_valid, rdy_n, mod_clk, held;
    logic [1:0] conv_mode;
    logic [3:0] word_rate_select, word_rate;
    logic [23:0] result_data, d, w, exp_w;
    line_out_t line_out;
    logic mod_q;
    int n_fail = 0, total_checks = 0, n_tog = 0;
    bit [31:0] seed;

    adc_serial_readout_port i_dut (.ref_clk(ref_clk), .rstn(rstn),
        .sclk(sclk), .cs_n(cs_n), .conv_mode(conv_mode),
        .word_rate_select(word_rate_select), .clock_source_sel_hi(sel_hi),
        .clock_source_sel_lo(sel_lo), .int_osc_clk(int_osc_clk),
        .ext_clk(ext_clk), .result_valid(result_valid),
        .result_data(result_data), .line_out(line_out), .rdy_n(rdy_n),
        .mod_clk(mod_clk), .word_rate(word_rate));

    serial_host_model i_host (.ref_clk(ref_clk), .line_out(line_out),
        .sclk(sclk), .cs_n(cs_n));

    initial forever #5 ref_clk = ~ref_clk;
    // Kept one ns after a ref_clk edge so sampling never races
    initial begin
        #6;
        forever #80 int_osc_clk = ~int_osc_clk;
    end

    always @(posedge ref_clk) begin
        if (mod_clk !== mod_q) n_tog++;
        mod_q <= mod_clk;
    end

    function automatic logic [23:0] offset_bin(input logic [23:0] v);
        return {~v[23], v[22:0]};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        tick(20000);
        n_fail++;
        summarize();
    end

    initial begin
        rstn = 1'b0;
        conv_mode = MODE_CONT_CONV;
        word_rate_select = 4'h0;
        {sel_hi, sel_lo, ext_clk, result_valid} = 4'h0;
        result_data = 24'h000000;
        seed = $urandom(32'h8564);
        tick(12);
        rstn = 1'b1;
        chk(rdy_n, 1'b1);
        chk(line_out.oe_n, 1'b1);
        for (int i = 0; i < 9; i++) begin
            d = i == 0 ? 24'h000000 : i == 1 ? 24'h7FFFFF :
                i == 2 ? 24'h800000 : 24'($urandom);
            conv_mode = 2'(i % 4);
            // New results only land while deselected, away from reads
            result_data = d;
            result_valid = 1'b1;
            word_rate_select = 4'($urandom);
            tick(1);
            result_valid = 1'b0;
            tick(2);
            chk(rdy_n, 1'b0);
            chk(word_rate, word_rate_select);
            i_host.select(1'b0);
            tick(3);
            chk(line_out.oe_n, 1'b0);
            chk(line_out.data, 1'b0);
            i_host.read_word(w, held);
            chk(w, offset_bin(d));
            chk(held, 1'b1);
            tick(3);
            chk(line_out.data, 1'b1);
            chk(rdy_n, 1'b1);
            i_host.read_word(w, held);
            exp_w = conv_mode == MODE_CONT_READ ? 24'hFFFFFF : offset_bin(d);
            chk(w, exp_w);
            i_host.select(1'b1);
            tick(3);
            chk(line_out.oe_n, 1'b1);
        end
        // Internal oscillator and the plain external clock pass straight on
        @(int_osc_clk);
        tick(1);
        chk(mod_clk, int_osc_clk);
        {sel_hi, sel_lo} = 2'h1;
        ext_clk = 1'b1;
        tick(1);
        chk(mod_clk, 1'b1);
        ext_clk = 1'b0;
        tick(1);
        chk(mod_clk, 1'b0);
        {sel_hi, sel_lo} = CLK_SRC_EXT_DIV2;
        tick(4);
        n_tog = 0;
        repeat (8) begin
            ext_clk = 1'b1;
            tick(4);
            ext_clk = 1'b0;
            tick(4);
        end
        tick(3);
        chk(n_tog, 8);
        summarize();
    end
endmodule

`default_nettype wire

// ---- tb/serial_host_model.sv ----
// Serial host model that frames reads of the converter readout port
`timescale 1ns/1ps
`default_nettype none

module serial_host_model
    import adc_readout_pkg::*;
(
    input wire logic ref_clk,
    input wire line_out_t line_out,
    output var logic sclk,
    output var logic cs_n
);
    // ============================================================
    // Board pin: a released line floats up to the pull-up
    wire logic pin;
    assign pin = line_out.oe_n ? 1'b1 : line_out.data;

    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
    end

    task automatic select(input logic lvl);
        @(posedge ref_clk);
        #1 cs_n = lvl;
    endtask

    // Three ref_clk cycles low and four high per bit, above the one the port needs
    task automatic read_word(output logic [23:0] w, output logic held);
        held = 1'b1;
        for (int i = 23; i >= 0; i--) begin
            @(posedge ref_clk);
            #1 sclk = 1'b0;
            repeat (3) @(posedge ref_clk);
            #1 w[i] = pin;
            sclk = 1'b1;
            repeat (3) @(posedge ref_clk);
            // The last rising edge ends the read, so the line must be high
            #1 held &= (pin === (i == 0 ? 1'b1 : w[i]));
        end
    endtask
endmodule

`default_nettype wire
